/* hw/aer_pkg.sv */
// Constants and carrier types of the error reporting register bank.
// Assumes one core clock; offsets are the byte addresses of 32-bit words.
package aer_pkg;
    localparam logic [11:0] AER_OFF_SEV = 12'h10c;
    localparam logic [11:0] AER_OFF_CFLAG = 12'h110;
    localparam logic [11:0] AER_OFF_CMASK = 12'h114;
    localparam logic [11:0] AER_OFF_CAPCTL = 12'h118;
    localparam logic [11:0] AER_OFF_HDR0 = 12'h11c;
    localparam logic [11:0] AER_OFF_HDR1 = 12'h120;
    localparam logic [11:0] AER_OFF_HDR2 = 12'h124;
    localparam logic [11:0] AER_OFF_HDR3 = 12'h128;
    localparam logic [11:0] AER_OFF_SFLAG = 12'h12c;
    localparam logic [11:0] AER_OFF_SMASK = 12'h130;
    localparam logic [11:0] AER_OFF_ISTAT = 12'h180;
    localparam logic [11:0] AER_OFF_ICLR = 12'h184;
    localparam logic [11:0] AER_OFF_IEN = 12'h188;

    localparam logic [31:0] AER_SEV_BITS = 32'h001f_f011;
    localparam logic [31:0] AER_SEV_RST = 32'h0006_2011;
    localparam logic [31:0] AER_CORR_BITS = 32'h0000_31c1;
    localparam logic [31:0] AER_CMASK_RST = 32'h0000_2000;
    localparam logic [31:0] AER_CAP_ONES = 32'h0000_00a0;
    localparam logic [31:0] AER_CAP_CTL_BITS = 32'h0000_0140;
    localparam logic [31:0] AER_SEC_BITS = 32'h0000_3fef;
    localparam logic [31:0] AER_SMASK_RST = 32'h0000_17a8;
    localparam int AER_PTR_MSB = 4;
    localparam int AER_GEN_EN_BIT = 6;
    localparam int AER_CHK_EN_BIT = 8;

    // Interrupt status bit positions.
    localparam int AER_IRQ_CORR = 0;
    localparam int AER_IRQ_NONFATAL = 1;
    localparam int AER_IRQ_FATAL = 2;
    localparam int AER_IRQ_SEC = 3;
    localparam int AER_IRQ_W = 4;

    typedef struct packed {
        logic [31:0] corr;
        logic [31:0] uncorr;
        logic [31:0] sec;
    } aer_evt_t;

    typedef struct packed {
        logic valid;
        logic [4:0] ptr;
        logic [15:0][7:0] hdr;
    } aer_log_t;

    typedef struct packed {
        logic [11:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } aer_req_t;

    typedef struct packed {
        logic [31:0] sev;
        logic [31:0] cflag;
        logic [31:0] cmask;
        logic [31:0] capctl;
        logic [3:0][31:0] hdr;
        logic [31:0] sflag;
        logic [31:0] smask;
        logic [AER_IRQ_W-1:0] istat;
        logic [AER_IRQ_W-1:0] ien;
        logic [AER_IRQ_W-1:0] rep;
        logic irq;
        logic [31:0] rdata;
    } aer_state_t;
endpackage

/* hw/aer_regs.sv */
// Error reporting register bank: severity, flags, masks, header log.
// Assumes error inputs are one-cycle pulses synchronous to clk_sys and
// that the primary uncorrectable events arrive already masked.
//
// The implementer's own choice: the strobed register port.
`timescale 1ns/1ps
module aer_regs
    import aer_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic ce,
    input wire logic hot_rst,
    input wire aer_req_t req,
    output logic [31:0] reg_rdata,
    input wire aer_evt_t evt,
    input wire aer_log_t log_in,
    output logic report_corr,
    output logic report_nonfatal,
    output logic report_fatal,
    output logic report_sec,
    output logic ecrc_gen_en,
    output logic ecrc_chk_en,
    output logic irq
);

    ////////////////////////////////////////////////////////////////////////
    aer_state_t state_q;
    aer_state_t state_d;
    logic [31:0] wd;
    logic [31:0] rd_mux;
    logic [31:0] corr_set;
    logic [31:0] sec_set;
    logic [AER_IRQ_W-1:0] ev;

    always_comb
    begin
        state_d = state_q;
        wd = req.wdata;
        corr_set = evt.corr & AER_CORR_BITS;
        sec_set = evt.sec & AER_SEC_BITS;
        rd_mux = 32'h0000_0000;
        // Reports only for unmasked errors; the corr and sec flags record masked ones too.
        ev[AER_IRQ_CORR] = |(corr_set & ~state_q.cmask);
        ev[AER_IRQ_NONFATAL] = |(evt.uncorr & AER_SEV_BITS & ~state_q.sev);
        ev[AER_IRQ_FATAL] = |(evt.uncorr & AER_SEV_BITS & state_q.sev);
        ev[AER_IRQ_SEC] = |(sec_set & ~state_q.smask);

        if (req.wr)
        begin
            case (req.addr)
                AER_OFF_SEV:
                    state_d.sev = wd & AER_SEV_BITS;
                AER_OFF_CFLAG:
                    state_d.cflag = state_q.cflag & ~wd;
                AER_OFF_CMASK:
                    state_d.cmask = wd & AER_CORR_BITS;
                AER_OFF_CAPCTL:
                begin
                    state_d.capctl = (state_q.capctl & ~AER_CAP_CTL_BITS)
                        | (wd & AER_CAP_CTL_BITS);
                end
                AER_OFF_SFLAG:
                    state_d.sflag = state_q.sflag & ~wd;
                AER_OFF_SMASK:
                    state_d.smask = wd & AER_SEC_BITS;
                AER_OFF_ICLR:
                    state_d.istat = state_q.istat & ~wd[AER_IRQ_W-1:0];
                AER_OFF_IEN:
                    state_d.ien = wd[AER_IRQ_W-1:0];
                default:
                    state_d.rdata = state_q.rdata;
            endcase
        end

        // Setting after the clear makes a same-cycle event win.
        state_d.cflag = state_d.cflag | corr_set;
        state_d.sflag = state_d.sflag | sec_set;
        state_d.istat = state_d.istat | ev;
        state_d.rep = ev;

        if (log_in.valid)
        begin
            state_d.capctl[AER_PTR_MSB:0] = log_in.ptr;
            for (int w = 0; w < 4; w++)
            begin
                state_d.hdr[w] = {log_in.hdr[4*w], log_in.hdr[4*w+1],
                    log_in.hdr[4*w+2], log_in.hdr[4*w+3]};
            end
        end

        case (req.addr)
            AER_OFF_SEV:
                rd_mux = state_q.sev;
            AER_OFF_CFLAG:
                rd_mux = state_q.cflag;
            AER_OFF_CMASK:
                rd_mux = state_q.cmask;
            AER_OFF_CAPCTL:
                rd_mux = state_q.capctl | AER_CAP_ONES;
            AER_OFF_HDR0:
                rd_mux = state_q.hdr[0];
            AER_OFF_HDR1:
                rd_mux = state_q.hdr[1];
            AER_OFF_HDR2:
                rd_mux = state_q.hdr[2];
            AER_OFF_HDR3:
                rd_mux = state_q.hdr[3];
            AER_OFF_SFLAG:
                rd_mux = state_q.sflag;
            AER_OFF_SMASK:
                rd_mux = state_q.smask;
            AER_OFF_ISTAT:
                rd_mux = {{(32-AER_IRQ_W){1'b0}}, state_q.istat};
            AER_OFF_IEN:
                rd_mux = {{(32-AER_IRQ_W){1'b0}}, state_q.ien};
            default:
                rd_mux = 32'h0000_0000;
        endcase
        // Read data stands only in the cycle after the strobe.
        state_d.rdata = req.rd ? rd_mux : 32'h0000_0000;
        state_d.irq = |(state_d.istat & state_d.ien);

        // A hot reset leaves the sticky fields alone and clears the rest.
        if (hot_rst)
        begin
            state_d.istat = '0;
            state_d.ien = '0;
            state_d.rep = '0;
            state_d.irq = 1'b0;
            state_d.rdata = 32'h0000_0000;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            state_q <= '0;
            state_q.sev <= AER_SEV_RST;
            state_q.cmask <= AER_CMASK_RST;
            state_q.smask <= AER_SMASK_RST;
        end
        else if (ce)
        begin
            state_q <= state_d;
        end
    end

    assign reg_rdata = state_q.rdata;
    assign report_corr = state_q.rep[AER_IRQ_CORR];
    assign report_nonfatal = state_q.rep[AER_IRQ_NONFATAL];
    assign report_fatal = state_q.rep[AER_IRQ_FATAL];
    assign report_sec = state_q.rep[AER_IRQ_SEC];
    assign ecrc_gen_en = state_q.capctl[AER_GEN_EN_BIT];
    assign ecrc_chk_en = state_q.capctl[AER_CHK_EN_BIT];
    assign irq = state_q.irq;

endmodule

/* tb/aer_regs_asserts.sv */
// Port checker of the error reporting register bank.
// Assumes the bind at the foot attaches it to every aer_regs instance.
`timescale 1ns/1ps
module aer_regs_asserts
    import aer_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic ce,
    input wire logic hot_rst,
    input wire aer_req_t req,
    input wire logic [31:0] reg_rdata,
    input wire aer_evt_t evt,
    input wire logic report_corr,
    input wire logic report_fatal,
    input wire logic report_sec,
    input wire logic ecrc_gen_en,
    input wire logic ecrc_chk_en
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    logic rd_ok;
    logic cw;
    // A hot reset clears read data, so reads beside it prove nothing.
    assign rd_ok = ce && req.rd && !hot_rst;
    assign cw = req.wr && req.addr == AER_OFF_CAPCTL;
    a_sev_rsvd: assert property (rd_ok && req.addr == AER_OFF_SEV |=>
        (reg_rdata & ~AER_SEV_BITS) == 32'h0) else $error("severity spare");
    a_sflag_rsvd: assert property (rd_ok && req.addr == AER_OFF_SFLAG |=>
        (reg_rdata & ~AER_SEC_BITS) == 32'h0) else $error("sec flag spare");
    a_cap_bits: assert property (rd_ok && req.addr == AER_OFF_CAPCTL |=>
        reg_rdata[7] && reg_rdata[5] && reg_rdata[31:9] == 23'h0)
        else $error("capability bits");
    a_corr_cause: assert property (report_corr |->
        $past(ce) && $past(evt.corr) != 32'h0) else $error("corr report");
    a_sec_cause: assert property (report_sec |->
        $past(ce) && $past(evt.sec) != 32'h0) else $error("sec report");
    a_fatal_cause: assert property (report_fatal |->
        $past(ce) && $past(evt.uncorr) != 32'h0) else $error("fatal report");
    a_gen_write: assert property ($changed(ecrc_gen_en) |->
        $past(cw) || $past(cw, 2)) else $error("gen enable moved");
    a_chk_write: assert property ($changed(ecrc_chk_en) |->
        $past(cw) || $past(cw, 2)) else $error("check enable moved");
endmodule
bind aer_regs aer_regs_asserts u_chk (.*);

/* tb/aer_regs_test.sv */
// Self-checking bench of the error reporting register bank.
// Assumes one 125 MHz clock and the read data in the cycle after a read.
`timescale 1ns/1ps
module aer_regs_test
    import aer_pkg::*;
;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic ce = 1'b1;
    logic hot_rst = 1'b0;
    aer_req_t req = '0;
    aer_evt_t evt = '0;
    aer_log_t log_in = '0;
    logic [31:0] reg_rdata;
    logic report_corr, report_nonfatal, report_fatal, report_sec;
    logic ecrc_gen_en, ecrc_chk_en, irq;
    int bad_count = 0;
    int n_tests = 0;
    logic [43:0] rows [11] = '{{AER_OFF_SEV, AER_SEV_RST},
        {AER_OFF_CFLAG, 32'h0}, {AER_OFF_CMASK, AER_CMASK_RST},
        {AER_OFF_CAPCTL, AER_CAP_ONES}, {AER_OFF_HDR0, 32'h0},
        {AER_OFF_HDR3, 32'h0}, {AER_OFF_SFLAG, 32'h0},
        {AER_OFF_SMASK, AER_SMASK_RST}, {AER_OFF_ISTAT, 32'h0},
        {AER_OFF_IEN, 32'h0}, {12'h200, 32'h0}};
    aer_regs dut (.*);
    always #4 clk_sys = ~clk_sys;
    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            bad_count++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk_sys);
        req.wr <= 1'b0;
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        @(posedge clk_sys);
        req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
        @(posedge clk_sys);
        req.rd <= 1'b0;
        #1 chk(reg_rdata, e);
    endtask
    // Reports come back as {corr, nonfatal, fatal, secondary}.
    task automatic ev(input logic [31:0] c, u, s, input logic [3:0] e);
        @(posedge clk_sys);
        evt <= {c, u, s};
        @(posedge clk_sys);
        evt <= '0;
        #1 chk({report_corr, report_nonfatal, report_fatal, report_sec}, e);
    endtask
    task automatic final_report;
        if (bad_count == 0 && n_tests > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (12) @(posedge clk_sys);
        rst <= 1'b0;
        foreach (rows[i])
            rd(rows[i][43:32], rows[i][31:0]);
        wr(AER_OFF_IEN, 32'hf);
        ev(32'h0, 32'h0, 32'h8, 4'h0);
        ev(32'h0, 32'h0, 32'h2047, 4'h1);
        rd(AER_OFF_SFLAG, 32'h204f);
        wr(AER_OFF_SFLAG, 32'hffff_0041);
        rd(AER_OFF_SFLAG, 32'h200e);
        ev(32'h2000, 32'h0, 32'h0, 4'h0);
        ev(32'h1000, 32'h0, 32'h0, 4'h8);
        wr(AER_OFF_CFLAG, 32'h1000);
        rd(AER_OFF_CFLAG, 32'h2000);
        ev(32'h0, 32'h10, 32'h0, 4'h2);
        ev(32'h0, 32'h1000, 32'h0, 4'h4);
        chk(irq, 1'b1);
        wr(AER_OFF_IEN, 32'h0);
        rd(AER_OFF_ISTAT, 32'hf);
        chk(irq, 1'b0);
        wr(AER_OFF_IEN, 32'hf);
        wr(AER_OFF_ICLR, 32'hf);
        rd(AER_OFF_ISTAT, 32'h0);
        chk(irq, 1'b0);
        wr(AER_OFF_SEV, '1);
        rd(AER_OFF_SEV, AER_SEV_BITS);
        wr(AER_OFF_CMASK, '1);
        rd(AER_OFF_CMASK, AER_CORR_BITS);
        wr(AER_OFF_SMASK, '1);
        rd(AER_OFF_SMASK, AER_SEC_BITS);
        wr(AER_OFF_CAPCTL, '1);
        rd(AER_OFF_CAPCTL, 32'h1e0);
        chk({ecrc_gen_en, ecrc_chk_en}, 2'h3);
        @(posedge clk_sys);
        log_in.valid <= 1'b1;
        log_in.ptr <= 5'h13;
        for (int n = 0; n < 16; n++)
            log_in.hdr[n] <= 8'h10 + n[7:0];
        @(posedge clk_sys);
        log_in.valid <= 1'b0;
        rd(AER_OFF_HDR0, 32'h1011_1213);
        rd(AER_OFF_HDR3, 32'h1c1d_1e1f);
        rd(AER_OFF_CAPCTL, 32'h1f3);
        // A hot reset must spare every sticky field but drop the interrupt enables.
        @(posedge clk_sys);
        hot_rst <= 1'b1;
        @(posedge clk_sys);
        hot_rst <= 1'b0;
        rd(AER_OFF_SEV, AER_SEV_BITS);
        rd(AER_OFF_HDR1, 32'h1415_1617);
        rd(AER_OFF_IEN, 32'h0);
        // With the clock enable low an event is lost and no flag is set.
        @(posedge clk_sys);
        ce <= 1'b0;
        ev(32'h1, 32'h0, 32'h0, 4'h0);
        @(posedge clk_sys);
        ce <= 1'b1;
        rd(AER_OFF_CFLAG, 32'h2000);
        // Only the power-on reset brings the sticky fields back.
        @(posedge clk_sys);
        rst <= 1'b1;
        repeat (2) @(posedge clk_sys);
        rst <= 1'b0;
        rd(AER_OFF_SEV, AER_SEV_RST);
        rd(AER_OFF_HDR1, 32'h0);
        rd(AER_OFF_CAPCTL, AER_CAP_ONES);
        chk({ecrc_gen_en, ecrc_chk_en}, 2'h0);
        final_report();
    end
endmodule
